// File: shared/ism_defs.vh
// Constants shared by the two-wire serial memory target and its APB register file
`ifndef ISM_DEFS_VH
`define ISM_DEFS_VH

// ****************************************************************
// Array geometry
// ****************************************************************
`define ISM_MEM_DEPTH 2048
`define ISM_ADDR_W 11
`define ISM_DATA_W 8
`define ISM_ADDR_TOP 11'h7FF
`define ISM_ADDR_ZERO 11'h000

// ****************************************************************
// Target address byte fields
// ****************************************************************
`define ISM_TYPE_HI 7
`define ISM_TYPE_LO 4
`define ISM_PAGE_HI 3
`define ISM_PAGE_LO 1
`define ISM_RW_BIT 0
`define ISM_BITS_PER_BYTE 4'h8

// ****************************************************************
// Serial clock limits
// ****************************************************************
`define ISM_SCL_MAX_KHZ 1000
`define ISM_CLK_MHZ 100

// ****************************************************************
// APB register offsets and fields
// ****************************************************************
`define ISM_REG_CTRL 12'h000
`define ISM_REG_STATUS 12'h004
`define ISM_REG_COUNT 12'h008
`define ISM_CTRL_EN 0
`define ISM_CTRL_SWP 1
`define ISM_CTRL_FREEZE 2
`define ISM_CTRL_RESET 3'h1
`define ISM_ST_BUSY 0
`define ISM_ST_WP 1
`define ISM_ST_FIFO_FULL 2
`define ISM_ST_ADDR_LO 16

// ****************************************************************
// Write buffer
// ****************************************************************
`define ISM_FIFO_DEPTH 16
`define ISM_FIFO_AW 4

`endif

// File: hdl/ism_fifo.v
// Synchronous valid/ready FIFO used as the commit buffer of the serial memory
`timescale 1ns/1ps
`default_nettype none
module ism_fifo #(
    parameter WIDTH = 19,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire clk_i,
    input wire reset_n_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] fill;
    wire push;
    wire pop;

    assign in_ready_o = (fill != DEPTH[AW:0]);
    assign out_valid_o = (fill != {(AW+1){1'b0}});
    assign out_data_o = store[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge clk_i)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                fill <= fill + 1'b1;
            end
            else if (pop && !push)
            begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule // ism_fifo
`default_nettype wire

// File: hdl/ism_top.v
// Two-wire serial target of a 2048 x 8 byte memory with APB control and status
`timescale 1ns/1ps
`default_nettype none
`include "ism_defs.vh"
module ism_top #(
    parameter [3:0] TYPE_CODE = 4'h5, // Arbitrary value
    parameter FIFO_DEPTH = `ISM_FIFO_DEPTH,
    parameter FIFO_AW = `ISM_FIFO_AW
)
(
    input wire clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire wp_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o
);
    // ****************************************************************
    // State codes
    // ****************************************************************
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_DEV = 4'h1;
    localparam [3:0] ST_DEV_ACK = 4'h2;
    localparam [3:0] ST_WORD = 4'h3;
    localparam [3:0] ST_WORD_ACK = 4'h4;
    localparam [3:0] ST_WDATA = 4'h5;
    localparam [3:0] ST_WDATA_ACK = 4'h6;
    localparam [3:0] ST_RDATA = 4'h7;
    localparam [3:0] ST_RACK = 4'h8;
    localparam FW = `ISM_ADDR_W + `ISM_DATA_W;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [`ISM_DATA_W-1:0] mem [0:`ISM_MEM_DEPTH-1];
    reg scl_m;
    reg scl_s;
    reg scl_q;
    reg sda_m;
    reg sda_s;
    reg sda_q;
    reg wp_m;
    reg wp_s;
    reg [3:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [7:0] tx;
    reg [2:0] page;
    reg [`ISM_ADDR_W-1:0] addr;
    reg master_ack;
    reg push_valid;
    reg [FW-1:0] push_data;
    reg [2:0] ctrl;
    reg [31:0] commit_cnt;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;
    wire blocked;
    wire fifo_ready;
    wire fifo_valid;
    wire [FW-1:0] fifo_data;
    wire drain_ready;
    wire [`ISM_ADDR_W-1:0] next_addr;
    wire apb_access;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    // Two flops on every pin; 100 MHz sampling leaves ample margin at a 1 MHz bus
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            wp_m <= 1'b0;
            wp_s <= 1'b0;
        end
        else
        begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_q <= sda_s;
            wp_m <= wp_i;
            wp_s <= wp_m;
        end
    end

    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_seen = scl_s && scl_q && sda_q && !sda_s;
    assign stop_seen = scl_s && scl_q && !sda_q && sda_s;
    // The pad pull-down keeps an open pin low, so reset value 0 matches it
    assign blocked = wp_s || ctrl[`ISM_CTRL_SWP];
    assign next_addr = (addr == `ISM_ADDR_TOP) ? `ISM_ADDR_ZERO : addr + 1'b1;

    // ****************************************************************
    // Serial target state machine
    // ****************************************************************
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            page <= 3'h0;
            addr <= `ISM_ADDR_ZERO;
            master_ack <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            push_valid <= 1'b0;
            push_data <= {FW{1'b0}};
        end
        else
        begin
            sda_o <= 1'b0;
            push_valid <= 1'b0;
            if (start_seen)
            begin
                state <= ST_DEV;
                bit_cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_DEV, ST_WORD, ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                        else if (scl_fall && bit_cnt == `ISM_BITS_PER_BYTE)
                        begin
                            bit_cnt <= 4'h0;
                            if (state == ST_DEV)
                            begin
                                if (shift[`ISM_TYPE_HI:`ISM_TYPE_LO] == TYPE_CODE && ctrl[`ISM_CTRL_EN])
                                begin
                                    page <= shift[`ISM_PAGE_HI:`ISM_PAGE_LO];
                                    master_ack <= shift[`ISM_RW_BIT];
                                    sda_oe_o <= 1'b1;
                                    state <= ST_DEV_ACK;
                                end
                                else
                                begin
                                    state <= ST_IDLE;
                                end
                            end
                            else if (state == ST_WORD)
                            begin
                                addr <= {page, shift};
                                sda_oe_o <= 1'b1;
                                state <= ST_WORD_ACK;
                            end
                            else if (fifo_ready)
                            begin
                                // Blocked bytes are acknowledged but never reach the buffer
                                push_valid <= !blocked;
                                push_data <= {addr, shift};
                                addr <= next_addr;
                                sda_oe_o <= 1'b1;
                                state <= ST_WDATA_ACK;
                            end
                            else
                            begin
                                // Full buffer: refuse the byte so the master can retry it
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_DEV_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (master_ack)
                            begin
                                // Read keeps the low byte of the latch, takes the new page
                                addr <= {page, addr[7:0]};
                                tx <= mem[{page, addr[7:0]}];
                                sda_oe_o <= !mem[{page, addr[7:0]}][7];
                                state <= ST_RDATA;
                            end
                            else
                            begin
                                sda_oe_o <= 1'b0;
                                state <= ST_WORD;
                            end
                        end
                    end
                    ST_WORD_ACK, ST_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_o <= 1'b0;
                            state <= ST_WDATA;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt == `ISM_BITS_PER_BYTE)
                            begin
                                sda_oe_o <= 1'b0;
                                addr <= next_addr;
                                state <= ST_RACK;
                            end
                            else
                            begin
                                tx <= {tx[6:0], 1'b0};
                                sda_oe_o <= !tx[6];
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            master_ack <= !sda_s;
                        end
                        else if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (master_ack)
                            begin
                                tx <= mem[addr];
                                sda_oe_o <= !mem[addr][7];
                                state <= ST_RDATA;
                            end
                            else
                            begin
                                sda_oe_o <= 1'b0;
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Commit buffer and array
    // ****************************************************************
    // Drains one byte per clock, far faster than one serial byte arrives
    assign drain_ready = !ctrl[`ISM_CTRL_FREEZE];

    ism_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(drain_ready),
        .out_data_o(fifo_data)
    );

    always @(posedge clk_i)
    begin
        if (fifo_valid && drain_ready)
        begin
            mem[fifo_data[FW-1:`ISM_DATA_W]] <= fifo_data[`ISM_DATA_W-1:0];
        end
    end

    // ****************************************************************
    // APB register file
    // ****************************************************************
    assign apb_access = psel_i && penable_i;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl <= `ISM_CTRL_RESET;
            commit_cnt <= 32'h00000000;
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            if (fifo_valid && drain_ready)
            begin
                commit_cnt <= commit_cnt + 32'h00000001;
            end
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            if (psel_i && !penable_i)
            begin
                case (paddr_i)
                    `ISM_REG_CTRL:
                    begin
                        prdata_o <= {29'h00000000, ctrl};
                    end
                    `ISM_REG_STATUS:
                    begin
                        prdata_o <= {5'h00, addr, 13'h0000, !fifo_ready, wp_s, state != ST_IDLE};
                    end
                    `ISM_REG_COUNT:
                    begin
                        prdata_o <= commit_cnt;
                    end
                    default:
                    begin
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
            if (apb_access && pready_o && pwrite_i)
            begin
                if (paddr_i == `ISM_REG_CTRL)
                begin
                    ctrl <= pwdata_i[2:0];
                end
                else if (paddr_i == `ISM_REG_COUNT)
                begin
                    commit_cnt <= 32'h00000000;
                end
            end
        end
    end
endmodule // ism_top
`default_nettype wire

// File: sim/ism_chk.sv
// Port-level assertions for the two-wire serial memory target
`timescale 1ns/1ps
`default_nettype none
`include "ism_defs.vh"
module ism_chk (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic wp_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // ********************
    // Serial line
    // ********************
    chk_sda_low_only: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    // The clock pin is synced by two flops, so a change follows a fall by three cycles or more
    chk_drive_after_fall: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("data line taken while clock high");
    chk_release_after_fall: assert property ($fell(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("data line released while clock high");
    chk_start_free: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o)
        else $error("data line held at a start");
    // ********************
    // APB
    // ********************
    chk_ready_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer in first access cycle");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    chk_slverr_map: assert property (pready_o |->
        pslverr_o == !(paddr_i inside {`ISM_REG_CTRL, `ISM_REG_STATUS, `ISM_REG_COUNT}))
        else $error("error response wrong for address");
    chk_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h00000000)
        else $error("read data outside answer");
    chk_status_wp: assert property (pready_o && !pwrite_i && paddr_i == `ISM_REG_STATUS
        && wp_i && $past(wp_i, 4) |-> prdata_o[`ISM_ST_WP])
        else $error("protect pin not seen in status");
endmodule // ism_chk
`default_nettype wire

// File: sim/ism_master.sv
// Two-wire bus controller model that clocks the memory target
`timescale 1ns/1ps
`default_nettype none
module ism_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Quarter of a 160 ns bit; the clock stands high between frames
    task automatic qtr;
        repeat (4) @(posedge clk_i);
    endtask
    // Data moves mid-low only; a one is a released line
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o <= !b;
        qtr;
        scl_o <= 1'b1;
        qtr;
        r = sda_i;
        qtr;
        scl_o <= 1'b0;
        qtr;
    endtask
    task automatic start;
        sda_oe_o <= 1'b0;
        qtr;
        scl_o <= 1'b1;
        qtr;
        sda_oe_o <= 1'b1;
        qtr;
        scl_o <= 1'b0;
        qtr;
    endtask
    task automatic stop;
        sda_oe_o <= 1'b1;
        qtr;
        scl_o <= 1'b1;
        qtr;
        sda_oe_o <= 1'b0;
        qtr;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    // Acknowledge asks for one more byte, a released line ends the read
    task automatic rd(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(!more, r);
    endtask
endmodule // ism_master
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of the two-wire serial memory target
`timescale 1ns/1ps
`default_nettype none
`include "ism_defs.vh"
module testbench;
    localparam logic [3:0] TC = 4'h5; // Arbitrary value
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wp_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    wire [31:0] prdata_o;
    wire pready_o;
    wire pslverr_o;
    wire sda_o;
    wire sda_oe_o;
    wire scl_i;
    wire m_oe;
    // Pull-up on the shared line; either side may only pull it low
    wire sda_i = (sda_oe_o ? sda_o : 1'b1) & !m_oe;
    int err_count = 0;
    int n_tests = 0;
    int seed = 32;
    int cnt = 0;
    int nb;
    logic [7:0] mem [0:2047];
    logic [10:0] lat;
    logic [10:0] a;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [7:0] d;
    logic ack;
    logic se;
    ism_top #(.TYPE_CODE(TC)) u_dut (.clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .wp_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
    ism_master u_mst (.clk_i, .sda_i, .scl_o(scl_i), .sda_oe_o(m_oe));
    always #5 clk_i = ~clk_i;
    // ********************
    // Tasks
    // ********************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                $display("ERROR %0t no bus answer", $time);
                tally_and_finish;
            end
            @(posedge clk_i);
        end
        r = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task rdchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, ad, 32'h00000000, rd);
        chk(rd & m, exp);
    endtask
    task i2c_wr(input logic [10:0] wa, input int n, input int lim, input logic prot);
        u_mst.start;
        u_mst.wr({TC, wa[10:8], 1'b0}, ack);
        chk(ack, 1);
        u_mst.wr(wa[7:0], ack);
        chk(ack, 1);
        lat = wa;
        for (int k = 0; k < n; k++)
        begin
            rnd = $random(seed);
            u_mst.wr(rnd[7:0], ack);
            chk(ack, k < lim);
            if (!prot && k < lim)
            begin
                mem[lat] = rnd[7:0];
                cnt++;
            end
            lat++;
        end
        u_mst.stop;
    endtask
    task i2c_rd(input logic [2:0] pg, input int n);
        u_mst.start;
        u_mst.wr({TC, pg, 1'b1}, ack);
        chk(ack, 1);
        lat = {pg, lat[7:0]};
        for (int k = 0; k < n; k++)
        begin
            u_mst.rd(k < n - 1, d);
            chk(d, mem[lat]);
            lat++;
        end
        u_mst.stop;
    endtask
    task nack_hdr(input logic [7:0] b);
        u_mst.start;
        u_mst.wr(b, ack);
        chk(ack, 0);
        u_mst.stop;
    endtask
    // ********************
    // Main sequence
    // ********************
    initial
    begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rdchk(`ISM_REG_CTRL, 32'hFFFFFFFF, 32'h00000001);
        rdchk(`ISM_REG_STATUS, 32'hFFFFFFFF, 32'h00000000);
        rdchk(`ISM_REG_COUNT, 32'hFFFFFFFF, 32'h00000000);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, rd);
        chk(se, 1);
        for (int i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            a = rnd[10:0];
            nb = 1 + rnd[13:12];
            i2c_wr(a, nb, 99, 1'b0);
            i2c_wr(a, 0, 99, 1'b0);
            i2c_rd(a[10:8], nb);
        end
        i2c_wr(11'h523, 1, 99, 1'b0);
        i2c_wr(11'h123, 0, 99, 1'b0);
        i2c_rd(3'h5, 1);
        i2c_wr(11'h7FE, 3, 99, 1'b0);
        rdchk(`ISM_REG_STATUS, 32'h07FF0000, 32'h00010000);
        i2c_wr(11'h7FE, 0, 99, 1'b0);
        i2c_rd(3'h7, 3);
        rdchk(`ISM_REG_COUNT, 32'hFFFFFFFF, cnt);
        apb(1'b1, `ISM_REG_COUNT, 32'h00000000, rd);
        rdchk(`ISM_REG_COUNT, 32'hFFFFFFFF, 32'h00000000);
        wp_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdchk(`ISM_REG_STATUS, 32'h00000002, 32'h00000002);
        i2c_wr(11'h7FE, 2, 99, 1'b1);
        rdchk(`ISM_REG_STATUS, 32'h07FF0000, 32'h00000000);
        wp_i <= 1'b0;
        apb(1'b1, `ISM_REG_CTRL, 32'h00000003, rd);
        i2c_wr(11'h7FF, 1, 99, 1'b1);
        apb(1'b1, `ISM_REG_CTRL, 32'h00000001, rd);
        i2c_wr(11'h7FE, 0, 99, 1'b0);
        i2c_rd(3'h7, 2);
        rdchk(`ISM_REG_COUNT, 32'hFFFFFFFF, 32'h00000000);
        apb(1'b1, `ISM_REG_CTRL, 32'h00000000, rd);
        nack_hdr({TC, 4'h0});
        apb(1'b1, `ISM_REG_CTRL, 32'h00000001, rd);
        nack_hdr({~TC, 4'h0});
        // Hold the drain so the buffer fills and refuses the byte after the last slot
        apb(1'b1, `ISM_REG_CTRL, 32'h00000005, rd);
        i2c_wr(11'h100, `ISM_FIFO_DEPTH + 1, `ISM_FIFO_DEPTH, 1'b0);
        rdchk(`ISM_REG_STATUS, 32'h00000004, 32'h00000004);
        apb(1'b1, `ISM_REG_CTRL, 32'h00000001, rd);
        i2c_wr(11'h100, 0, 99, 1'b0);
        i2c_rd(3'h1, `ISM_FIFO_DEPTH);
        tally_and_finish;
    end
endmodule // testbench
bind ism_top ism_chk u_chk (.clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .wp_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
`default_nettype wire
